// ==== alt_pkg.sv ====
// package for the address lookup table manual access block
// assumes a single aclk domain and an axi4-lite register slave
package alt_pkg;
	// register indices; byte address is four times the index
	localparam logic [15:0] ALT_IDX_COMMAND        = 16'h1800;
	localparam logic [15:0] ALT_IDX_WRITE_LOW      = 16'h1801;
	localparam logic [15:0] ALT_IDX_WRITE_HIGH     = 16'h1802;
	localparam logic [15:0] ALT_IDX_READ_LOW       = 16'h1803;
	localparam logic [15:0] ALT_IDX_READ_HIGH      = 16'h1804;
	localparam logic [15:0] ALT_IDX_COMMAND_STATUS = 16'h1805;

	localparam int ALT_BIT_GET_NEXT   = 0;
	localparam int ALT_BIT_GET_FIRST  = 1;
	localparam int ALT_BIT_MAKE_ENTRY = 2;
	localparam int ALT_BIT_VALID      = 24;
	localparam int ALT_BIT_STATIC     = 22;
	localparam int ALT_BIT_FILTER     = 21;
	localparam int ALT_BIT_MAKE_PEND  = 0;
	localparam int ALT_BIT_READ_VALID = 1;
	localparam int ALT_MAC_HIGH_BITS  = 16;

	localparam int ALT_DEPTH     = 16;
	localparam int ALT_IDX_WIDTH = 4;

	localparam logic [31:0] ALT_RESET_WORD = 32'h0000_0000;
	localparam logic [1:0]  ALT_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  ALT_RESP_SLVERR = 2'h2;
endpackage

// ==== alt_table_if.sv ====
// carries table requests between the register front end and the table store
// assumes both ends run on aclk
interface alt_table_if;
	import alt_pkg::*;
	logic                     make_strobe;
	logic [31:0]              make_low;
	logic [31:0]              make_high;
	logic                     read_strobe;
	logic [ALT_IDX_WIDTH-1:0] read_index;
	logic                     busy;
	logic                     entry_valid;
	logic [31:0]              entry_low;
	logic [31:0]              entry_high;
	modport front (output make_strobe, make_low, make_high, read_strobe, read_index,
		input busy, entry_valid, entry_low, entry_high);
	modport store (input make_strobe, make_low, make_high, read_strobe, read_index,
		output busy, entry_valid, entry_low, entry_high);
endinterface

// ==== alt_table_store.sv ====
// table storage in flip-flops; finds a slot and writes one entry per make
// assumes the front end issues one make at a time and waits on busy
module alt_table_store
	import alt_pkg::*;
(
	input  wire logic  aclk,
	input  wire logic  aresetn,
	alt_table_if.store tbl
);
	logic [31:0]              low_mem   [ALT_DEPTH];
	logic [31:0]              high_mem  [ALT_DEPTH];
	logic [ALT_DEPTH-1:0]     valid_mem;
	logic                     busy;
	logic [ALT_IDX_WIDTH-1:0] slot;
	logic                     slot_found;

	// -------------------------------------------------------------
	// slot choice: the matching address wins, else the first free slot
	// -------------------------------------------------------------
	always_comb begin
		slot       = '0;
		slot_found = 1'b0;
		for (int i = ALT_DEPTH - 1; i >= 0; i--) begin
			if (!valid_mem[i]) begin
				slot       = ALT_IDX_WIDTH'(i);
				slot_found = 1'b1;
			end
		end
		for (int i = ALT_DEPTH - 1; i >= 0; i--) begin
			if (valid_mem[i] && low_mem[i] == tbl.make_low
				&& high_mem[i][ALT_MAC_HIGH_BITS-1:0] == tbl.make_high[ALT_MAC_HIGH_BITS-1:0]) begin
				slot       = ALT_IDX_WIDTH'(i);
				slot_found = 1'b1;
			end
		end
	end

	// -------------------------------------------------------------
	// write side; a clear valid bit deletes the matched entry
	// -------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			valid_mem <= '0;
			busy      <= 1'b0;
		end else begin
			busy <= tbl.make_strobe;
			if (tbl.make_strobe && slot_found) begin
				low_mem[slot]   <= tbl.make_low;
				high_mem[slot]  <= tbl.make_high;
				valid_mem[slot] <= tbl.make_high[ALT_BIT_VALID];
			end
		end
	end

	assign tbl.busy        = busy;
	// only a running scan may see a valid slot, so a stale pointer never loads data
	assign tbl.entry_valid = tbl.read_strobe && valid_mem[tbl.read_index];
	assign tbl.entry_low   = low_mem[tbl.read_index];
	assign tbl.entry_high  = high_mem[tbl.read_index];
endmodule

// ==== alt_manual_access.sv ====
// axi4-lite front end for manual table access: command, staging, read-back
// assumes aclk at 25 MHz, synchronous active-low reset, one access at a time
module alt_manual_access
	import alt_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             entry_multicast,
	output logic             entry_static,
	output logic             entry_filter
);
	typedef enum logic [1:0] {ALT_WALK_IDLE, ALT_WALK_SCAN} alt_walk_type;

	alt_table_if tbl ();

	logic [2:0]               table_command;
	logic [31:0]              table_write_data_low;
	logic [31:0]              table_write_data_high;
	logic [31:0]              table_read_data_low;
	logic [31:0]              table_read_data_high;
	logic                     make_pending;
	logic                     read_found;
	logic [ALT_IDX_WIDTH-1:0] read_pointer;
	logic [ALT_IDX_WIDTH:0]   scan_left;
	alt_walk_type             walk;
	logic [31:0]              aw_hold;
	logic                     aw_have;
	logic [31:0]              w_hold;
	logic [3:0]               ws_hold;
	logic                     w_have;
	logic                     make_strobe;

	function automatic logic [15:0] reg_index(input logic [31:0] addr);
		return addr[17:2];
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		for (int b = 0; b < 4; b++)
			if (strb[b])
				old[b*8 +: 8] = data[b*8 +: 8];
		return old;
	endfunction

	// -------------------------------------------------------------
	// write channel capture and decode
	// -------------------------------------------------------------
	wire        write_go    = aw_have && w_have && !s_axi_bvalid;
	wire        aw_take     = s_axi_awvalid && s_axi_awready;
	wire        w_take      = s_axi_wvalid && s_axi_wready;
	wire [15:0] write_index = reg_index(aw_hold);
	wire        wr_cmd      = write_go && write_index == ALT_IDX_COMMAND;
	wire        wr_low      = write_go && write_index == ALT_IDX_WRITE_LOW;
	wire        wr_high     = write_go && write_index == ALT_IDX_WRITE_HIGH;
	wire        wr_ro       = write_go && (write_index == ALT_IDX_READ_LOW
		|| write_index == ALT_IDX_READ_HIGH || write_index == ALT_IDX_COMMAND_STATUS);
	wire [31:0] cmd_word    = merge({29'h0, table_command}, w_hold, ws_hold);
	wire [2:0]  next_command = cmd_word[2:0];
	wire [2:0]  cmd_rise    = wr_cmd ? (next_command & ~table_command) : 3'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have      <= 1'b0;
			w_have       <= 1'b0;
			aw_hold      <= ALT_RESET_WORD;
			w_hold       <= ALT_RESET_WORD;
			ws_hold      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= ALT_RESP_OKAY;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			// ready is a flop: low from the take until the held pair is consumed
			s_axi_awready <= write_go || (!aw_have && !aw_take);
			s_axi_wready  <= write_go || (!w_have && !w_take);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have <= 1'b1;
				aw_hold <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have  <= 1'b1;
				w_hold  <= s_axi_wdata;
				ws_hold <= s_axi_wstrb;
			end
			if (write_go) begin
				aw_have      <= 1'b0;
				w_have       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_cmd || wr_low || wr_high || wr_ro) ? ALT_RESP_OKAY : ALT_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// -------------------------------------------------------------
	// command, staging and status registers
	// -------------------------------------------------------------
	assign make_strobe = cmd_rise[ALT_BIT_MAKE_ENTRY];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			table_command         <= 3'h0;
			table_write_data_low  <= ALT_RESET_WORD;
			table_write_data_high <= ALT_RESET_WORD;
			make_pending          <= 1'b0;
		end else begin
			if (wr_cmd)
				table_command <= next_command;
			if (wr_low)
				table_write_data_low <= merge(table_write_data_low, w_hold, ws_hold);
			if (wr_high)
				table_write_data_high <= merge(table_write_data_high, w_hold, ws_hold);
			if (make_strobe)
				make_pending <= 1'b1;
			else if (tbl.busy)
				make_pending <= 1'b0;
		end
	end

	// -------------------------------------------------------------
	// read pointer walk: one slot per cycle, the whole table on get first, the other 15 slots on get next
	// -------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			walk                 <= ALT_WALK_IDLE;
			read_pointer         <= '0;
			scan_left            <= '0;
			read_found           <= 1'b0;
			table_read_data_low  <= ALT_RESET_WORD;
			table_read_data_high <= ALT_RESET_WORD;
		end else begin
			case (walk)
				ALT_WALK_IDLE: begin
					if (cmd_rise[ALT_BIT_GET_FIRST]) begin
						read_pointer <= '0;
						scan_left    <= (ALT_IDX_WIDTH+1)'(ALT_DEPTH);
						walk         <= ALT_WALK_SCAN;
					end else if (cmd_rise[ALT_BIT_GET_NEXT]) begin
						read_pointer <= read_pointer + 1'b1;
						scan_left    <= (ALT_IDX_WIDTH+1)'(ALT_DEPTH - 1);
						walk         <= ALT_WALK_SCAN;
					end
				end
				ALT_WALK_SCAN: begin
					if (scan_left == '0) begin
						read_found           <= 1'b0;
						table_read_data_low  <= ALT_RESET_WORD;
						table_read_data_high <= ALT_RESET_WORD;
						walk                 <= ALT_WALK_IDLE;
					end else if (tbl.entry_valid) begin
						read_found           <= 1'b1;
						table_read_data_low  <= tbl.entry_low;
						table_read_data_high <= tbl.entry_high;
						walk                 <= ALT_WALK_IDLE;
					end else begin
						read_pointer <= read_pointer + 1'b1;
						scan_left    <= scan_left - 1'b1;
					end
				end
				default: walk <= ALT_WALK_IDLE;
			endcase
		end
	end

	assign tbl.make_strobe = make_strobe;
	assign tbl.make_low    = table_write_data_low;
	assign tbl.make_high   = table_write_data_high;
	assign tbl.read_strobe = walk == ALT_WALK_SCAN;
	assign tbl.read_index  = read_pointer;

	alt_table_store store (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tbl     (tbl)
	);

	// -------------------------------------------------------------
	// read channel
	// -------------------------------------------------------------
	wire [15:0] read_index = reg_index(s_axi_araddr);
	wire        read_hit   = read_index >= ALT_IDX_COMMAND && read_index <= ALT_IDX_COMMAND_STATUS;
	wire        walk_busy  = walk != ALT_WALK_IDLE;
	wire [31:0] status_word = {30'h0, read_found && !walk_busy, make_pending || walk_busy};
	wire [31:0] read_word  =
		read_index == ALT_IDX_COMMAND        ? {29'h0, table_command} :
		read_index == ALT_IDX_WRITE_LOW      ? table_write_data_low :
		read_index == ALT_IDX_WRITE_HIGH     ? table_write_data_high :
		read_index == ALT_IDX_READ_LOW       ? table_read_data_low :
		read_index == ALT_IDX_READ_HIGH      ? table_read_data_high :
		read_index == ALT_IDX_COMMAND_STATUS ? status_word : ALT_RESET_WORD;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= ALT_RESET_WORD;
			s_axi_rresp   <= ALT_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= read_word;
				s_axi_rresp  <= read_hit ? ALT_RESP_OKAY : ALT_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// -------------------------------------------------------------
	// staged entry flags, seen by the forwarding path
	// -------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			entry_multicast <= 1'b0;
			entry_static    <= 1'b0;
			entry_filter    <= 1'b0;
		end else begin
			entry_multicast <= table_write_data_low[0];
			entry_static    <= table_write_data_high[ALT_BIT_STATIC];
			entry_filter    <= table_write_data_high[ALT_BIT_FILTER];
		end
	end
endmodule

// ==== alt_manual_access_checker.sv ====
// port checker for the manual table access block
// assumes it is bound to every alt_manual_access instance, one aclk domain
module alt_manual_access_checker
	import alt_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        entry_multicast,
	input wire logic        entry_static,
	input wire logic        entry_filter
);
	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ---------------------------------------------
	// handshakes
	// ---------------------------------------------
	wire wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire rd_take = s_axi_arvalid && s_axi_arready;
	wire wr_low  = wr_both && s_axi_awaddr[17:0] == 18'h06004;
	wire wr_high = wr_both && s_axi_awaddr[17:0] == 18'h06008;
	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	arready_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("arready longer than one cycle");
	read_latency_a: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	write_latency_a: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	read_error_a: assert property (rd_take && s_axi_araddr[17:0] == 18'h06018 |=> s_axi_rresp == ALT_RESP_SLVERR)
		else $error("unmapped read not refused");
	write_error_a: assert property (wr_both && s_axi_awaddr[17:0] == 18'h06018
		|-> ##[1:2] (s_axi_bvalid && s_axi_bresp == ALT_RESP_SLVERR)) else $error("unmapped write not refused");
	cmd_upper_a: assert property (rd_take && s_axi_araddr[17:0] == 18'h06000 |=> s_axi_rdata[31:3] == 29'h0)
		else $error("command upper bits not zero");
	multicast_flag_a: assert property (wr_low |-> ##3 entry_multicast == $past(s_axi_wdata[0], 3))
		else $error("multicast flag wrong");
	static_flag_a: assert property (wr_high |-> ##3 entry_static == $past(s_axi_wdata[22], 3))
		else $error("static flag wrong");
	filter_flag_a: assert property (wr_high |-> ##3 entry_filter == $past(s_axi_wdata[21], 3))
		else $error("filter flag wrong");
endmodule

bind alt_manual_access alt_manual_access_checker i_chk (
	.aclk            (aclk),
	.aresetn         (aresetn),
	.s_axi_awaddr    (s_axi_awaddr),
	.s_axi_awvalid   (s_axi_awvalid),
	.s_axi_awready   (s_axi_awready),
	.s_axi_wdata     (s_axi_wdata),
	.s_axi_wstrb     (s_axi_wstrb),
	.s_axi_wvalid    (s_axi_wvalid),
	.s_axi_wready    (s_axi_wready),
	.s_axi_bresp     (s_axi_bresp),
	.s_axi_bvalid    (s_axi_bvalid),
	.s_axi_bready    (s_axi_bready),
	.s_axi_araddr    (s_axi_araddr),
	.s_axi_arvalid   (s_axi_arvalid),
	.s_axi_arready   (s_axi_arready),
	.s_axi_rdata     (s_axi_rdata),
	.s_axi_rresp     (s_axi_rresp),
	.s_axi_rvalid    (s_axi_rvalid),
	.s_axi_rready    (s_axi_rready),
	.entry_multicast (entry_multicast),
	.entry_static    (entry_static),
	.entry_filter    (entry_filter)
);

// ==== tb_top.sv ====
// self-checking bench for the manual table access block
// assumes the checker file is compiled alongside for its bind
module tb_top
	import alt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic wr; logic [31:0] a; logic [31:0] d; logic [1:0] resp;} alt_row_type;
	logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        entry_multicast, entry_static, entry_filter;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [31:0] s_axi_rdata, rdv, lo, hi, st;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	int          error_cnt = 0, samples_checked = 0;
	alt_row_type rows [10] = '{
		'{1'b0, 32'h0000_6000, 32'h0000_0000, ALT_RESP_OKAY},
		'{1'b0, 32'h0000_6004, 32'h0000_0000, ALT_RESP_OKAY},
		'{1'b1, 32'h0000_6000, 32'hFFFF_FFF8, ALT_RESP_OKAY},
		'{1'b0, 32'h0000_6000, 32'h0000_0000, ALT_RESP_OKAY},
		'{1'b1, 32'h0000_6004, 32'hA1B2_C3D5, ALT_RESP_OKAY},
		'{1'b0, 32'h0000_6004, 32'hA1B2_C3D5, ALT_RESP_OKAY},
		'{1'b1, 32'h0000_6008, 32'h0160_1234, ALT_RESP_OKAY},
		'{1'b0, 32'h0000_6008, 32'h0160_1234, ALT_RESP_OKAY},
		'{1'b1, 32'h0000_6018, 32'h0000_0005, ALT_RESP_SLVERR},
		'{1'b0, 32'h0000_6018, 32'h0000_0000, ALT_RESP_SLVERR}};
	alt_manual_access i_dut (
		.aclk            (aclk),
		.aresetn         (aresetn),
		.s_axi_awaddr    (s_axi_awaddr),
		.s_axi_awvalid   (s_axi_awvalid),
		.s_axi_awready   (s_axi_awready),
		.s_axi_wdata     (s_axi_wdata),
		.s_axi_wstrb     (s_axi_wstrb),
		.s_axi_wvalid    (s_axi_wvalid),
		.s_axi_wready    (s_axi_wready),
		.s_axi_bresp     (s_axi_bresp),
		.s_axi_bvalid    (s_axi_bvalid),
		.s_axi_bready    (s_axi_bready),
		.s_axi_araddr    (s_axi_araddr),
		.s_axi_arvalid   (s_axi_arvalid),
		.s_axi_arready   (s_axi_arready),
		.s_axi_rdata     (s_axi_rdata),
		.s_axi_rresp     (s_axi_rresp),
		.s_axi_rvalid    (s_axi_rvalid),
		.s_axi_rready    (s_axi_rready),
		.entry_multicast (entry_multicast),
		.entry_static    (entry_static),
		.entry_filter    (entry_filter)
	);
	always #20 aclk = ~aclk;
	// ---------------------------------------------
	// bus tasks, each entered just after a rising edge
	// ---------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
		logic aw_t, w_t, b;
		int   n;
		b = 1'b0;
		n = 0;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		// sample before the edge that the handshake falls on, release right after it
		while (!b && n < 100) begin
			@(negedge aclk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t  = s_axi_wvalid && s_axi_wready;
			b    = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge aclk);
			if (aw_t)
				s_axi_awvalid <= 1'b0;
			if (w_t)
				s_axi_wvalid <= 1'b0;
			n++;
		end
		s_axi_bready <= 1'b0;
		if (!b)
			error_cnt++;
		@(posedge aclk);
	endtask
	task automatic axi_read(input logic [31:0] a);
		logic ar_t, r;
		int   n;
		r = 1'b0;
		n = 0;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		while (!r && n < 100) begin
			@(negedge aclk);
			ar_t = s_axi_arvalid && s_axi_arready;
			r    = s_axi_rvalid;
			rdv  = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge aclk);
			if (ar_t)
				s_axi_arvalid <= 1'b0;
			n++;
		end
		s_axi_rready <= 1'b0;
		if (!r)
			error_cnt++;
		@(posedge aclk);
	endtask
	// scans take up to one cycle more than a table's depth, so poll the busy bit
	task automatic poll_idle();
		for (int i = 0; i < 20; i++) begin
			axi_read(32'h0000_6014);
			if (rdv[ALT_BIT_MAKE_PEND] === 1'b0)
				return;
		end
		// a walk that never ends is a mismatch of its own
		error_cnt++;
	endtask
	task automatic command(input logic [31:0] c);
		axi_write(32'h0000_6000, c);
		poll_idle();
		st = rdv;
		axi_write(32'h0000_6000, 32'h0);
		axi_read(32'h0000_600C);
		lo = rdv;
		axi_read(32'h0000_6010);
		hi = rdv;
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		#200us;
		error_cnt++;
		conclude();
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		foreach (rows[i]) begin
			if (rows[i].wr) axi_write(rows[i].a, rows[i].d);
			else begin
				axi_read(rows[i].a);
				check(rdv, rows[i].d);
			end
			check({30'h0, resp}, {30'h0, rows[i].resp});
		end
		$display("register rows done");
		check({29'h0, entry_multicast, entry_static, entry_filter}, 32'h7);
		command(32'h4);
		check({31'h0, st[ALT_BIT_MAKE_PEND]}, 32'h0);
		command(32'h2);
		check({31'h0, st[1]}, 32'h1);
		check(lo, 32'hA1B2_C3D5);
		check(hi, 32'h0160_1234);
		command(32'h1);
		check({31'h0, st[1]}, 32'h0);
		check(lo, 32'h0);
		$display("make and walk done");
		axi_write(32'h6008, 32'h01001234);
		command(32'h4);
		command(32'h2);
		check(hi, 32'h01001234);
		axi_write(32'h6008, 32'h00001234);
		command(32'h4);
		command(32'h2);
		check({31'h0, st[1]}, 32'h0);
		$display("modify and delete done");
		// reset in mid-run with a command bit and a staging word left set
		axi_write(32'h0000_6004, 32'h0000_0001);
		axi_write(32'h0000_6000, 32'h0000_0004);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(32'h0000_6000);
		check(rdv, 32'h0);
		axi_read(32'h0000_6004);
		check(rdv, 32'h0);
		check({29'h0, entry_multicast, entry_static, entry_filter}, 32'h0);
		$display("reset test done");
		conclude();
	end
endmodule
